// ==== cbmr_pkg.sv ====
// Functional notes
// - Little-endian byte lanes on every port
// - One flat 32-bit 4GByte address space
// - Coupled-memory fetches use instruction code port
// - Coupled-memory data uses data code port
// - Other on-chip addresses use system port
// - Decoder picks one port or private bus
// - Bit-band accesses always use system port
// - Different blocks: code and data parallel
// - Same block: code then data, two cycles
// - Single-entry write buffer for system-port writes
// - Private peripheral bus is 32-bit APB
// - Debugger reaches all memory over the data path when core data is idle
package cbmr_pkg;
    // Coupled memory window and its two blocks
    localparam logic [31:0] CBMR_CCM_BASE   = 32'h0000_0000;
    localparam logic [31:0] CBMR_CCM_LIMIT  = 32'h1fff_ffff;
    // Block select bit inside coupled memory
    localparam int          CBMR_BLK_BIT    = 28;
    // Bit-band alias regions
    localparam logic [31:0] CBMR_BB_SRAM_LO = 32'h2200_0000;
    localparam logic [31:0] CBMR_BB_SRAM_HI = 32'h23ff_ffff;
    localparam logic [31:0] CBMR_BB_PERI_LO = 32'h4200_0000;
    localparam logic [31:0] CBMR_BB_PERI_HI = 32'h43ff_ffff;
    // Private peripheral bus window
    localparam logic [31:0] CBMR_PPB_LO     = 32'he000_0000;
    localparam logic [31:0] CBMR_PPB_HI     = 32'he00f_ffff;
    // Port selection codes
    typedef enum logic [1:0] {
        CBMR_PORT_INSTR,
        CBMR_PORT_DATA,
        CBMR_PORT_SYS,
        CBMR_PORT_PPB
    } cbmr_port_type;
endpackage : cbmr_pkg

// ==== cbmr_decode.sv ====
module cbmr_decode (
    input  wire logic [31:0]            addr_i,  // Byte address
    input  wire logic                   fetch_i, // Instruction fetch
    output cbmr_pkg::cbmr_port_type     port_o   // Selected port
);
    // One target per address, flat space
    // single address space
    always_comb
    begin
        if (addr_i >= cbmr_pkg::CBMR_PPB_LO && addr_i <= cbmr_pkg::CBMR_PPB_HI)
            port_o = cbmr_pkg::CBMR_PORT_PPB;
        else if (addr_i <= cbmr_pkg::CBMR_CCM_LIMIT)
            port_o = fetch_i ? cbmr_pkg::CBMR_PORT_INSTR : cbmr_pkg::CBMR_PORT_DATA;
        else
            port_o = cbmr_pkg::CBMR_PORT_SYS;
    end
endmodule : cbmr_decode

// ==== cbmr_router.sv ====
module cbmr_router (
    input  wire logic        clk_i,         // Core clock
    input  wire logic        rst_i,         // Sync reset, high
    // Core fetch request
    input  wire logic        f_req_i,       // Fetch request
    input  wire logic [31:0] f_addr_i,      // Fetch address
    output logic             f_ack_o,       // Fetch accepted
    // Core data request
    input  wire logic        d_req_i,       // Data request
    input  wire logic        d_write_i,     // Write
    input  wire logic [31:0] d_addr_i,      // Data address
    input  wire logic [31:0] d_wdata_i,     // Write data, little-endian
    input  wire logic [3:0]  d_be_i,        // Byte enables
    output logic             d_ack_o,       // Data accepted
    // Debugger request
    input  wire logic        g_req_i,       // Debug request
    input  wire logic        g_write_i,     // Debug write
    input  wire logic [31:0] g_addr_i,      // Debug address
    input  wire logic [31:0] g_wdata_i,     // Debug write data
    output logic             g_ack_o,       // Debug accepted
    // Instruction code port (AHB-Lite)
    output logic [1:0]       ic_htrans_o,   // Transfer type
    output logic [31:0]      ic_haddr_o,    // Address
    input  wire logic        ic_hready_i,   // Ready
    // Data code port (AHB-Lite)
    output logic [1:0]       dc_htrans_o,   // Transfer type
    output logic [31:0]      dc_haddr_o,    // Address
    output logic             dc_hwrite_o,   // Write
    output logic [31:0]      dc_hwdata_o,   // Write data
    input  wire logic        dc_hready_i,   // Ready
    // System port (AHB-Lite)
    output logic [1:0]       sy_htrans_o,   // Transfer type
    output logic [31:0]      sy_haddr_o,    // Address
    output logic             sy_hwrite_o,   // Write
    output logic [31:0]      sy_hwdata_o,   // Write data
    input  wire logic        sy_hready_i,   // Ready
    // Private peripheral bus (APB)
    output logic             pp_psel_o,     // Select
    output logic             pp_penable_o,  // Enable
    output logic             pp_pwrite_o,   // Write
    output logic [31:0]      pp_paddr_o,    // Address
    output logic [31:0]      pp_pwdata_o,   // Write data
    input  wire logic        pp_pready_i    // Ready
);
    localparam logic [1:0] HT_IDLE = 2'h0;
    localparam logic [1:0] HT_NSEQ = 2'h2;

    typedef struct packed {
        logic        serial;   // Same-block data held one cycle
        logic        wb_vld;   // Write buffer full
        logic [31:0] wb_addr;  // Buffered address
        logic [31:0] wb_data;  // Buffered data
        logic        pp_act;   // APB access phase
    } cbmr_state_type;

    cbmr_state_type s_r, s_nxt;
    cbmr_pkg::cbmr_port_type fport, dport;
    logic [31:0] d_addr;
    logic        d_src_dbg;

    // Debugger takes the data path when the core makes no data request
    // debugger shares data path
    assign d_src_dbg = g_req_i && !d_req_i;
    assign d_addr    = d_src_dbg ? g_addr_i : d_addr_i;

    cbmr_decode u_fdec (.addr_i(f_addr_i), .fetch_i(1'b1), .port_o(fport));
    cbmr_decode u_ddec (.addr_i(d_addr), .fetch_i(1'b0), .port_o(dport));

    logic same_blk, conflict, d_go, f_go, d_wr;
    logic [31:0] d_wd;
    logic [31:0] be_mask;   // Byte enables spread over their lanes
    logic        d_sys_rd;  // Data read aimed at the system port
    logic        f_sys_ok;  // System port free for a fetch
    assign d_wr = d_src_dbg ? g_write_i : d_write_i;
    assign be_mask = {{8{d_be_i[3]}}, {8{d_be_i[2]}}, {8{d_be_i[1]}}, {8{d_be_i[0]}}};
    // bytes pass in lane order, no swap
    // Disabled core lanes go out as zero; the debugger always writes whole words
    assign d_wd = d_src_dbg ? g_wdata_i : (d_wdata_i & be_mask);
    assign same_blk = f_addr_i[cbmr_pkg::CBMR_BLK_BIT] == d_addr[cbmr_pkg::CBMR_BLK_BIT];
    assign conflict = f_req_i && (d_req_i || g_req_i) && dport == cbmr_pkg::CBMR_PORT_DATA
                      && fport == cbmr_pkg::CBMR_PORT_INSTR && same_blk;

    // System port sharing between data and fetch
    // data read wins, fetch when free
    // A waiting load stalls the pipe at once, a fetch has prefetch slack
    assign d_sys_rd = (d_req_i || g_req_i) && !d_wr && dport == cbmr_pkg::CBMR_PORT_SYS;
    // Buffered write drains first, so a fetch never overtakes it
    assign f_sys_ok = sy_hready_i && !s_r.wb_vld && !d_sys_rd;

    // Grants: fetch first, data waits one cycle on conflict
    always_comb
    begin
        f_go = f_req_i && ic_hready_i && fport == cbmr_pkg::CBMR_PORT_INSTR;
        if (fport == cbmr_pkg::CBMR_PORT_SYS)
            f_go = f_req_i && f_sys_ok;
        d_go = (d_req_i || g_req_i) && (!conflict || s_r.serial);
        if (dport == cbmr_pkg::CBMR_PORT_DATA)
            d_go = d_go && dc_hready_i;
        else if (dport == cbmr_pkg::CBMR_PORT_SYS)
            d_go = d_go && (d_wr ? !s_r.wb_vld : (sy_hready_i && !s_r.wb_vld));
        else
            d_go = d_go && s_r.pp_act && pp_pready_i;
    end

    // Next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.serial = conflict && !s_r.serial;
        if (s_r.wb_vld && sy_hready_i)
            s_nxt.wb_vld = 1'b0;
        if (d_go && dport == cbmr_pkg::CBMR_PORT_SYS && d_wr)
        begin
            s_nxt.wb_vld  = 1'b1;
            s_nxt.wb_addr = d_addr;
            s_nxt.wb_data = d_wd;
        end
        s_nxt.pp_act = (d_req_i || g_req_i) && dport == cbmr_pkg::CBMR_PORT_PPB && !(s_r.pp_act && pp_pready_i);
        if (rst_i)
            s_nxt = '0;
    end

    always_ff @(posedge clk_i)
    begin
        s_r <= s_nxt;
    end

    // Port drive
    // address phase driven by core
    always_comb
    begin
        f_ack_o      = f_go;
        d_ack_o      = d_go && !d_src_dbg;
        g_ack_o      = d_go && d_src_dbg;
        ic_htrans_o  = (f_go && fport == cbmr_pkg::CBMR_PORT_INSTR) ? HT_NSEQ : HT_IDLE;
        ic_haddr_o   = f_addr_i;
        dc_htrans_o  = (d_go && dport == cbmr_pkg::CBMR_PORT_DATA) ? HT_NSEQ : HT_IDLE;
        dc_haddr_o   = d_addr;
        dc_hwrite_o  = d_wr;
        dc_hwdata_o  = d_wd;
        // Buffered write drains before reads, keeping order
        sy_htrans_o  = (s_r.wb_vld || (d_go && d_sys_rd)
                        || (f_go && fport == cbmr_pkg::CBMR_PORT_SYS)) ? HT_NSEQ : HT_IDLE;
        // Buffer, then data read, then fetch
        if (s_r.wb_vld)
            sy_haddr_o = s_r.wb_addr;
        else if (d_sys_rd)
            sy_haddr_o = d_addr;
        else
            sy_haddr_o = f_addr_i;
        sy_hwrite_o  = s_r.wb_vld;
        sy_hwdata_o  = s_r.wb_data;
        pp_psel_o    = (d_req_i || g_req_i) && dport == cbmr_pkg::CBMR_PORT_PPB;
        pp_penable_o = s_r.pp_act;
        pp_pwrite_o  = d_wr;
        pp_paddr_o   = d_addr;
        pp_pwdata_o  = d_wd;
    end

    // First cycle of a same-block clash
    sequence s_clash;
        conflict && !s_r.serial;
    endsequence

    property p_serial;
        @(posedge clk_i) disable iff (rst_i)
        s_clash |-> !d_go ##1 s_r.serial;
    endproperty
    a_serial: assert property (p_serial) else $error("serial slot missing");

    // Pending write held back by the system port
    sequence s_wb_stall;
        s_r.wb_vld && !sy_hready_i;
    endsequence

    property p_wbuf;
        @(posedge clk_i) disable iff (rst_i)
        s_wb_stall |=> s_r.wb_vld && $stable(s_r.wb_addr) && $stable(s_r.wb_data);
    endproperty
    a_wbuf: assert property (p_wbuf) else $error("write buffer overrun");

    property p_parallel;
        @(posedge clk_i) disable iff (rst_i)
        f_req_i && d_req_i && ic_hready_i && dc_hready_i && !same_blk
        && fport == cbmr_pkg::CBMR_PORT_INSTR && dport == cbmr_pkg::CBMR_PORT_DATA
        |-> f_ack_o && d_ack_o;
    endproperty
    a_parallel: assert property (p_parallel) else $error("parallel grant missing");

    property p_fetch_ic;
        @(posedge clk_i) disable iff (rst_i)
        f_req_i && ic_hready_i && f_addr_i <= cbmr_pkg::CBMR_CCM_LIMIT |-> f_ack_o && ic_htrans_o == HT_NSEQ;
    endproperty
    a_fetch_ic: assert property (p_fetch_ic) else $error("fetch off instruction port");

    // Granted data access inside a bit-band alias
    sequence s_bb_go;
        d_go && ((d_addr >= cbmr_pkg::CBMR_BB_SRAM_LO && d_addr <= cbmr_pkg::CBMR_BB_SRAM_HI)
                 || (d_addr >= cbmr_pkg::CBMR_BB_PERI_LO && d_addr <= cbmr_pkg::CBMR_BB_PERI_HI));
    endsequence

    property p_bitband;
        @(posedge clk_i) disable iff (rst_i)
        s_bb_go |-> dc_htrans_o == HT_IDLE && !pp_psel_o && (d_wr || sy_htrans_o == HT_NSEQ);
    endproperty
    a_bitband: assert property (p_bitband) else $error("bit-band off system port");

    // APB setup phase seen on the private bus
    sequence s_apb_setup;
        pp_psel_o && !pp_penable_o;
    endsequence

    property p_apb;
        @(posedge clk_i) disable iff (rst_i)
        s_apb_setup |=> pp_penable_o;
    endproperty
    a_apb: assert property (p_apb) else $error("private bus access phase missing");

    property p_one_port;
        @(posedge clk_i) disable iff (rst_i)
        d_go |-> $onehot({dc_htrans_o == HT_NSEQ, pp_psel_o, dport == cbmr_pkg::CBMR_PORT_SYS});
    endproperty
    a_one_port: assert property (p_one_port) else $error("data sent to several ports");
endmodule : cbmr_router

// ==== cbmr_mem_model.sv ====
module cbmr_mem_model (
    input  wire logic clk_i,  // Core clock
    input  wire logic slow_i, // Insert wait states
    output logic      rdy_o   // Ready for every port
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wait-state phase; with slow_i ready every other cycle, else ready every cycle
    logic ph_r = 1'b0;
    always_ff @(posedge clk_i) ph_r <= slow_i ? ~ph_r : 1'b1;
    assign rdy_o = ph_r;
endmodule : cbmr_mem_model

// ==== cbmr_router_test.sv ====
module cbmr_router_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, slow = 0, rdy;
    logic        f_req_i = 0, d_req_i = 0, d_write_i = 0, g_req_i = 0, g_write_i = 0;
    logic [31:0] f_addr_i = 0, d_addr_i = 0, d_wdata_i = 0, g_addr_i = 0, g_wdata_i = 0;
    logic [3:0]  d_be_i = 4'hf;
    logic        f_ack_o, d_ack_o, g_ack_o, dc_hwrite_o, sy_hwrite_o, pp_psel_o, pp_penable_o, pp_pwrite_o;
    logic [1:0]  ic_htrans_o, dc_htrans_o, sy_htrans_o;
    logic [31:0] ic_haddr_o, dc_haddr_o, dc_hwdata_o, sy_haddr_o, sy_hwdata_o, pp_paddr_o, pp_pwdata_o;
    logic [31:0] lfsr = 32'h0000_0038;
    logic [31:0] tbl [5] = '{32'h0000_0100, 32'h1000_0200, 32'h2000_0040, 32'h2200_0010, 32'he000_e010};
    int          n_fail = 0, n_checks = 0;
    cbmr_mem_model mem_u (.clk_i(clk_i), .slow_i(slow), .rdy_o(rdy));
    cbmr_router dut_u (.*, .ic_hready_i(rdy), .dc_hready_i(rdy), .sy_hready_i(rdy), .pp_pready_i(rdy));
    initial forever #4 clk_i = ~clk_i;
    // Compare and count
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Model of the decoder: 0 instr, 1 data, 2 system, 3 private bus
    function int exp_port(input logic [31:0] a, input int k);
        // alias ranges reach the system port
        if ((a >= cbmr_pkg::CBMR_BB_SRAM_LO && a <= cbmr_pkg::CBMR_BB_SRAM_HI) ||
            (a >= cbmr_pkg::CBMR_BB_PERI_LO && a <= cbmr_pkg::CBMR_BB_PERI_HI)) return 2;
        if (a <= cbmr_pkg::CBMR_CCM_LIMIT) return (k == 0) ? 0 : 1;
        if (a >= cbmr_pkg::CBMR_PPB_LO && a <= cbmr_pkg::CBMR_PPB_HI) return 3;
        return 2;
    endfunction : exp_port
    // Feedback shift step for random addresses
    function logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nx
    // Drop every request, called just after a falling edge
    task drop_req;
        f_req_i = 0;
        d_req_i = 0;
        g_req_i = 0;
        d_write_i = 0;
        g_write_i = 0;
    endtask : drop_req
    // One access: k 0 fetch, 1 data, 2 debugger; held until acknowledged
    task acc(input int k, input logic [31:0] a, input logic w);
        int          p;
        logic        ack;
        logic        bw;
        logic [31:0] wd;
        @(negedge clk_i);
        f_req_i = k == 0;
        d_req_i = k == 1;
        g_req_i = k == 2;
        f_addr_i = a;
        d_addr_i = a;
        g_addr_i = a;
        d_write_i = w;
        g_write_i = w;
        d_wdata_i = ~a;
        g_wdata_i = ~a;
        // Core writes only its enabled lanes, the debugger whole words
        wd = (k == 2) ? ~a : ~a & {{8{d_be_i[3]}}, {8{d_be_i[2]}}, {8{d_be_i[1]}}, {8{d_be_i[0]}}};
        // System writes go to the buffer and show on the port a cycle later
        bw = k != 0 && w && exp_port(a, k) == 2;
        ack = 0;
        for (int i = 0; i < 12 && ack !== 1'b1; i++)
        begin
            #1 ack = (k == 0) ? f_ack_o : (k == 1) ? d_ack_o : g_ack_o;
            if (ack !== 1'b1) @(negedge clk_i);
        end
        check("ack", ack, 1);
        if (bw)
        begin
            @(negedge clk_i);
            drop_req();
            #1;
        end
        p = ic_htrans_o[1] === 1'b1 ? 0 : dc_htrans_o[1] === 1'b1 ? 1 : pp_psel_o === 1'b1 ? 3 :
            sy_htrans_o[1] === 1'b1 ? 2 : 7;
        check("port", p, exp_port(a, k));
        check("addr", p == 0 ? ic_haddr_o : p == 1 ? dc_haddr_o : p == 2 ? sy_haddr_o : pp_paddr_o, a);
        if (k != 0) check("write", p == 1 ? dc_hwrite_o : p == 2 ? sy_hwrite_o : pp_pwrite_o, w);
        if (k != 0 && w) check("wdata", p == 1 ? dc_hwdata_o : p == 2 ? sy_hwdata_o : pp_pwdata_o, wd);
        if (!bw)
        begin
            @(negedge clk_i);
            drop_req();
        end
    endtask : acc
    task tally_and_finish;
        $display("Checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // Watchdog well beyond the longest expected run
    initial
    begin
        #20000;
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        @(negedge clk_i) rst_i = 0;
        // Each table address from each requester; fetch to the private bus is left out
        for (int k = 0; k < 3; k++)
            for (int i = 0; i < 5; i++)
                if (!(k == 0 && i == 4)) acc(k, tbl[i], k != 0 && i[0]);
        $display("Routing test done");
        // Random data addresses with a stalling memory side
        slow = 1;
        repeat (10)
        begin
            lfsr = nx(lfsr);
            d_be_i = lfsr[3:0];
            acc(1, lfsr, lfsr[4]);
        end
        slow = 0;
        d_be_i = 4'hf;
        $display("Random test done");
        // Same block serialises, different blocks run in parallel
        for (int j = 0; j < 2; j++)
        begin
            @(negedge clk_i);
            f_req_i = 1; f_addr_i = 32'h0000_0100; d_req_i = 1; d_addr_i = j ? 32'h1000_0200 : 32'h0000_0200;
            #1 check("f_ack", f_ack_o, 1);
            check("d_ack", d_ack_o, j);
            @(negedge clk_i) f_req_i = 0;
            if (j == 0) #1 check("d_ack late", d_ack_o, 1);
            if (j == 0) @(negedge clk_i);
            d_req_i = 0;
        end
        $display("Conflict test done");
        tally_and_finish();
    end
endmodule : cbmr_router_test
